/* File: src/p2t_bridge.sv */
`timescale 1ns/1ns
`default_nettype none
`include "p2t_map.svh"

module p2t_bridge (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Stream link
  p2t_link_if.bridge        link,
  // Memory-mapped master
  output logic [31:0]       avm_address_o,
  output logic              avm_read_o,
  output logic              avm_write_o,
  output logic [31:0]       avm_writedata_o,
  output logic [3:0]        avm_byteenable_o,
  input  wire logic [31:0]  avm_readdata_i,
  input  wire logic         avm_waitrequest_i
);

  p2t_pkg::state_e state;
  logic [7:0]      code;
  logic [15:0]     size;
  logic [31:0]     addr;
  logic [2:0]      hcnt;
  logic [15:0]     done_cnt;
  logic [31:0]     wbuf;
  logic [3:0]      wbe;
  logic [1:0]      lane;
  logic            wlast;
  logic [31:0]     rbuf;
  logic [2:0]      ridx;
  logic            first;
  logic            take;
  logic            give;
  logic            rd_done;
  logic            wr_done;
  logic [15:0]     remain;
  logic [4:0]      bitpos;

  function automatic logic is_wr(input logic [7:0] c);
    is_wr = (c == `P2T_CODE_WR_FIX) || (c == `P2T_CODE_WR_INC);
  endfunction

  function automatic logic is_rd(input logic [7:0] c);
    is_rd = (c == `P2T_CODE_RD_FIX) || (c == `P2T_CODE_RD_INC);
  endfunction

  function automatic logic is_inc(input logic [7:0] c);
    is_inc = (c == `P2T_CODE_WR_INC) || (c == `P2T_CODE_RD_INC);
  endfunction

  function automatic logic [15:0] lanes(input logic [3:0] be);
    lanes = {15'h0000, be[0]} + {15'h0000, be[1]}
          + {15'h0000, be[2]} + {15'h0000, be[3]};
  endfunction

  // Next state after the packet has closed; reads need something to fetch
  function automatic p2t_pkg::state_e after_eop(input logic [7:0] c,
                                                input logic [15:0] s);
    if (is_rd(c) && (s != 16'h0000))
      after_eop = p2t_pkg::ST_RBUS;
    else
      after_eop = p2t_pkg::ST_RESP;
  endfunction

  // Sink only open while collecting; no ready during bus or reply phases
  assign link.req_ready = (state == p2t_pkg::ST_HDR)
                       || (state == p2t_pkg::ST_WCOL)
                       || (state == p2t_pkg::ST_SKIP);
  assign take    = link.req_valid && link.req_ready;
  assign remain  = size - done_cnt;
  assign bitpos  = {lane, 3'b000};

  assign avm_address_o    = {addr[31:2], 2'b00};
  assign avm_writedata_o  = wbuf;
  assign avm_byteenable_o = wbe;
  // Single accesses only; read held off while the source is stalled
  assign avm_write_o = (state == p2t_pkg::ST_WBUS);
  assign avm_read_o  = (state == p2t_pkg::ST_RBUS)
                    && link.rsp_ready;
  assign wr_done = avm_write_o && !avm_waitrequest_i;
  assign rd_done = avm_read_o && !avm_waitrequest_i;

  // Response stream; no error or channel signals exist on it
  always_comb
  begin
    link.rsp_valid = 1'b0;
    link.rsp_data  = 8'h00;
    link.rsp_sop   = 1'b0;
    link.rsp_eop   = 1'b0;
    if (state == p2t_pkg::ST_RSEND)
    begin
      link.rsp_valid = 1'b1;
      link.rsp_data  = rbuf[bitpos +: 8];
      link.rsp_sop   = first;
      link.rsp_eop   = (remain == 16'h0001);
    end
    else if (state == p2t_pkg::ST_RESP)
    begin
      link.rsp_valid = 1'b1;
      link.rsp_sop   = (ridx == 3'h0);
      link.rsp_eop   = (ridx == `P2T_RSP_LAST);
      case (ridx)
        3'h0:    link.rsp_data = code ^ `P2T_CODE_INV;
        3'h1:    link.rsp_data = 8'h00;
        3'h2:    link.rsp_data = 8'h00;
        3'h3:    link.rsp_data = done_cnt[15:8];
        3'h4:    link.rsp_data = done_cnt[7:0];
        default: link.rsp_data = 8'h00;
      endcase
    end
  end
  assign give = link.rsp_valid && link.rsp_ready;

  // Transaction sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= p2t_pkg::ST_HDR;
    else if (take && link.req_sop)
      state <= p2t_pkg::ST_HDR;
    else
    begin
      case (state)
        p2t_pkg::ST_HDR:
          if (take && (hcnt == `P2T_HDR_LAST))
          begin
            if (!link.req_eop)
              state <= is_wr(code) ? p2t_pkg::ST_WCOL : p2t_pkg::ST_SKIP;
            else
              state <= is_wr(code) ? p2t_pkg::ST_RESP
                                   : after_eop(code, size);
          end
        p2t_pkg::ST_SKIP:
          if (take && link.req_eop)
            state <= after_eop(code, size);
        p2t_pkg::ST_WCOL:
          if (take && (link.req_eop || (lane == 2'h3)))
            state <= p2t_pkg::ST_WBUS;
        p2t_pkg::ST_WBUS:
          if (wr_done)
            state <= wlast ? p2t_pkg::ST_RESP : p2t_pkg::ST_WCOL;
        p2t_pkg::ST_RBUS:
          if (rd_done)
            state <= p2t_pkg::ST_RSEND;
        p2t_pkg::ST_RSEND:
          if (give && link.rsp_eop)
            state <= p2t_pkg::ST_HDR;
          else if (give && (lane == 2'h3))
            state <= p2t_pkg::ST_RBUS;
        p2t_pkg::ST_RESP:
          if (give && (ridx == `P2T_RSP_LAST))
            state <= p2t_pkg::ST_HDR;
        default:
          state <= p2t_pkg::ST_HDR;
      endcase
    end
  end

  // Header capture; a header cut short by EOP is dropped silently
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hcnt <= 3'h0;
      code <= 8'h00;
      size <= 16'h0000;
    end
    else if (take && link.req_sop)
    begin
      code <= link.req_data;
      hcnt <= 3'h1;
    end
    else if (take && (state == p2t_pkg::ST_HDR) && (hcnt != 3'h0))
    begin
      if (hcnt == `P2T_HDR_SIZE_HI)
        size[15:8] <= link.req_data;
      if (hcnt == `P2T_HDR_SIZE_LO)
        size[7:0] <= link.req_data;
      hcnt <= link.req_eop ? 3'h0 : hcnt + 3'h1;
    end
    else if (state != p2t_pkg::ST_HDR)
      hcnt <= 3'h0;
  end

  // Address: loaded msb first, stepped per word only when incrementing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr <= 32'h0000_0000;
    else if (take && (state == p2t_pkg::ST_HDR) && !link.req_sop
             && (hcnt >= `P2T_HDR_ADDR_0))
      addr <= {addr[23:0], link.req_data};
    // Fixed-address codes leave addr alone
    else if ((wr_done || rd_done) && is_inc(code))
      addr <= addr + `P2T_WORD_STEP;
  end

  // Write word assembly; bytes map to lanes in arrival order
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wbuf  <= 32'h0000_0000;
      wbe   <= 4'h0;
      wlast <= 1'b0;
    end
    else if (take && (state == p2t_pkg::ST_WCOL) && !link.req_sop)
    begin
      wbuf[bitpos +: 8] <= link.req_data;
      wbe[lane]         <= 1'b1;
      wlast             <= link.req_eop;
    end
    else if (wr_done || (state == p2t_pkg::ST_HDR))
      wbe <= 4'h0;
  end

  // Lane pointer shared by write packing and read unpacking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lane <= 2'h0;
    else if ((take && (state == p2t_pkg::ST_WCOL) && !link.req_sop)
             || (give && (state == p2t_pkg::ST_RSEND)))
      lane <= lane + 2'h1;
    else if ((state == p2t_pkg::ST_HDR) || wr_done || rd_done)
      lane <= 2'h0;
  end

  // Byte count reported back, and read data holding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_cnt <= 16'h0000;
      rbuf     <= 32'h0000_0000;
      first    <= 1'b0;
    end
    else if (state == p2t_pkg::ST_HDR)
    begin
      done_cnt <= 16'h0000;
      first    <= 1'b1;
    end
    else
    begin
      if (wr_done)
        done_cnt <= done_cnt + lanes(wbe);
      if (rd_done)
        rbuf <= avm_readdata_i;
      // Word is held until sent, so backpressure never drops a byte
      if (give && (state == p2t_pkg::ST_RSEND))
      begin
        done_cnt <= done_cnt + 16'h0001;
        first    <= 1'b0;
      end
    end
  end

  // Response byte index
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (state != p2t_pkg::ST_RESP))
      ridx <= 3'h0;
    else if (give)
      ridx <= ridx + 3'h1;
  end

endmodule

`default_nettype wire

/* File: src/p2t_map.svh */
`ifndef P2T_MAP_SVH
`define P2T_MAP_SVH

`define P2T_CODE_WR_FIX  8'h00
`define P2T_CODE_WR_INC  8'h04
`define P2T_CODE_RD_FIX  8'h10
`define P2T_CODE_RD_INC  8'h14
`define P2T_CODE_NULL    8'h7F
`define P2T_CODE_INV     8'h80
`define P2T_HDR_CODE     3'h0
`define P2T_HDR_SIZE_HI  3'h2
`define P2T_HDR_SIZE_LO  3'h3
`define P2T_HDR_ADDR_0   3'h4
`define P2T_HDR_LAST     3'h7
`define P2T_RSP_LAST     3'h4
`define P2T_WORD_STEP    32'h0000_0004
`define P2T_FIFO_DEPTH   32
`define P2T_FIFO_WIDTH   10

`endif

/* File: src/p2t_pkg.sv */
package p2t_pkg;

  typedef enum logic [2:0] {
    ST_HDR   = 3'b000,
    ST_WCOL  = 3'b001,
    ST_WBUS  = 3'b011,
    ST_RESP  = 3'b010,
    ST_RBUS  = 3'b110,
    ST_RSEND = 3'b111,
    ST_SKIP  = 3'b101
  } state_e;

  typedef logic [7:0] sym_t;

endpackage

/* File: src/p2t_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface p2t_link_if;
  // Request stream, source end to bridge
  logic            req_valid;
  logic            req_ready;
  p2t_pkg::sym_t   req_data;
  logic            req_sop;
  logic            req_eop;
  // Response stream, bridge to source end
  logic            rsp_valid;
  logic            rsp_ready;
  p2t_pkg::sym_t   rsp_data;
  logic            rsp_sop;
  logic            rsp_eop;

  modport bridge (
    input  req_valid, req_data, req_sop, req_eop, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_sop, rsp_eop
  );
  modport source (
    output req_valid, req_data, req_sop, req_eop, rsp_ready,
    input  req_ready, rsp_valid, rsp_data, rsp_sop, rsp_eop
  );
endinterface

`default_nettype wire

/* File: src/p2t_source.sv */
`timescale 1ns/1ns
`default_nettype none
`include "p2t_map.svh"

module p2t_fifo #(
  parameter int W = `P2T_FIFO_WIDTH,
  parameter int D = `P2T_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Fill side
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [W-1:0]  in_data_i,
  // Drain side
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic [W-1:0]       out_data_o
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  logic         full;
  logic         empty;

  assign empty       = (wptr == rptr);
  assign full        = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (in_valid_i && !full)
      mem[wptr[AW-1:0]] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (in_valid_i && !full)
        wptr <= wptr + 1'b1;
      if (out_ready_i && !empty)
        rptr <= rptr + 1'b1;
    end
  end

endmodule

module p2t_source (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Stream link
  p2t_link_if.source        link,
  // Request bytes from user
  input  wire logic         tx_valid_i,
  output logic              tx_ready_o,
  input  wire logic [7:0]   tx_data_i,
  input  wire logic         tx_sop_i,
  input  wire logic         tx_eop_i,
  // Response bytes to user
  output logic              rx_valid_o,
  input  wire logic         rx_ready_i,
  output logic [7:0]        rx_data_o,
  output logic              rx_sop_o,
  output logic              rx_eop_o
);

  logic [9:0] head;

  // Buffer lets the user queue up to 32 request bytes while the bridge is busy
  p2t_fifo #(
    .W (`P2T_FIFO_WIDTH),
    .D (`P2T_FIFO_DEPTH)
  ) tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_sop_i, tx_eop_i, tx_data_i}),
    .out_valid_o (link.req_valid),
    .out_ready_i (link.req_ready),
    .out_data_o  (head)
  );
  // Payload length matching size is left to the user
  assign link.req_sop  = head[9];
  assign link.req_eop  = head[8];
  assign link.req_data = head[7:0];

  // One-deep output register; ready to the bridge is combinational
  assign link.rsp_ready = !rx_valid_o || rx_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_sop_o   <= 1'b0;
      rx_eop_o   <= 1'b0;
    end
    else if (link.rsp_ready)
    begin
      rx_valid_o <= link.rsp_valid;
      rx_data_o  <= link.rsp_data;
      rx_sop_o   <= link.rsp_sop;
      rx_eop_o   <= link.rsp_eop;
    end
  end

endmodule

`default_nettype wire

/* File: dv/p2t_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module p2t_checker (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Link
  input  wire logic           req_ready,
  input  wire logic           rsp_valid,
  input  wire logic           rsp_ready,
  input  wire p2t_pkg::sym_t  rsp_data,
  input  wire logic           rsp_sop,
  input  wire logic           rsp_eop,
  // Bus master
  input  wire logic [31:0]    avm_address_o,
  input  wire logic           avm_read_o,
  input  wire logic           avm_write_o,
  input  wire logic           avm_waitrequest_i
);
  logic in_pkt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Open response packet, so a stray SOP mid-packet is caught
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_pkt <= 1'b0;
    else if (rsp_valid && rsp_ready)
      in_pkt <= !rsp_eop;
  end

  AST_RSP_HOLD: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid
      && $stable({rsp_data, rsp_sop, rsp_eop}))
    else $error("response beat changed while stalled");
  AST_SOP_FIRST: assert property (
    rsp_valid |-> rsp_sop == !in_pkt)
    else $error("response start marker misplaced");
  AST_READ_GATED: assert property (
    avm_read_o |-> rsp_ready)
    else $error("read issued while response stalled");
  AST_ONE_ACCESS: assert property (
    !(avm_read_o && avm_write_o))
    else $error("read and write together");
  AST_ALIGN: assert property (
    avm_read_o || avm_write_o |-> avm_address_o[1:0] == 2'h0)
    else $error("unaligned bus address");
  AST_WAIT_STALL: assert property (
    avm_write_o && avm_waitrequest_i |=> avm_write_o && !req_ready
      && $stable(avm_address_o))
    else $error("write not held under waitrequest");
  AST_ONE_TXN: assert property (
    rsp_valid |-> !req_ready)
    else $error("sink ready while answering");
  AST_READY_BACK: assert property (
    rsp_valid && rsp_ready && rsp_eop |-> ##[1:3] req_ready)
    else $error("sink ready not restored");
endmodule

`default_nettype wire

/* File: dv/packet_to_bus_transaction_bridge_test.sv */
`timescale 1ns/1ns
`default_nettype none

module packet_to_bus_transaction_bridge_test;
  logic        clk_i;
  logic        rst_i;
  logic        tx_valid_i;
  logic        tx_ready_o;
  logic [7:0]  tx_data_i;
  logic        tx_sop_i;
  logic        tx_eop_i;
  logic        rx_valid_o;
  logic        rx_ready_i;
  logic [7:0]  rx_data_o;
  logic        rx_sop_o;
  logic        rx_eop_o;
  logic [31:0] avm_address_o;
  logic        avm_read_o;
  logic        avm_write_o;
  logic [31:0] avm_writedata_o;
  logic [3:0]  avm_byteenable_o;
  logic [31:0] avm_readdata_i;
  logic        avm_waitrequest_i;
  logic [31:0] mem [64];
  logic [7:0]  pk [$];
  logic [7:0]  ex [$];
  logic [9:0]  rq [$];
  logic [7:0]  odd [3] = '{8'h7F, 8'h33, 8'hFF};
  int          error_cnt;
  int          checked;
  int          acc_cnt;
  int          acc0;
  int          wn;

  p2t_link_if link ();
  p2t_source i_p2t_source (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_data_i(tx_data_i), .tx_sop_i(tx_sop_i), .tx_eop_i(tx_eop_i),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_data_o(rx_data_o), .rx_sop_o(rx_sop_o), .rx_eop_o(rx_eop_o));
  p2t_bridge i_p2t_bridge (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .avm_address_o(avm_address_o), .avm_read_o(avm_read_o),
    .avm_write_o(avm_write_o), .avm_writedata_o(avm_writedata_o),
    .avm_byteenable_o(avm_byteenable_o),
    .avm_readdata_i(avm_readdata_i),
    .avm_waitrequest_i(avm_waitrequest_i));
  p2t_checker i_p2t_checker (.clk_i(clk_i), .rst_i(rst_i),
    .req_ready(link.req_ready), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data),
    .rsp_sop(link.rsp_sop), .rsp_eop(link.rsp_eop),
    .avm_address_o(avm_address_o), .avm_read_o(avm_read_o),
    .avm_write_o(avm_write_o), .avm_waitrequest_i(avm_waitrequest_i));

  // Slave shows garbage when not read, so a stale sample is caught
  assign avm_readdata_i = avm_read_o ? mem[avm_address_o[7:2]]
                                     : ~mem[avm_address_o[7:2]];

  always @(posedge clk_i)
  begin
    if ((avm_write_o || avm_read_o) && !avm_waitrequest_i)
      acc_cnt++;
    if (avm_write_o && !avm_waitrequest_i)
      for (int k = 0; k < 4; k++)
        if (avm_byteenable_o[k])
          mem[avm_address_o[7:2]][8*k +: 8] <= avm_writedata_o[8*k +: 8];
  end

  always @(posedge clk_i)
    if (rx_valid_o && rx_ready_i)
      rq.push_back({rx_sop_o, rx_eop_o, rx_data_o});

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task stop_test;
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task hdr(input logic [7:0] code, input logic [15:0] size,
           input logic [31:0] a);
    pk = {code, 8'h00, size[15:8], size[7:0], a[31:24], a[23:16],
          a[15:8], a[7:0]};
  endtask

  task data(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++)
      pk.push_back(base + 8'(k));
  endtask

  task rsp5(input logic [7:0] code, input logic [15:0] cnt);
    ex = {code ^ 8'h80, 8'h00, 8'h00, cnt[15:8], cnt[7:0]};
  endtask

  // Called at 1 ns after an edge; returns at the same phase
  task send(input bit eop);
    int n;
    bit hs;
    for (int i = 0; i < pk.size(); i++)
    begin
      tx_valid_i = 1'b1;
      tx_data_i = pk[i];
      tx_sop_i = (i == 0);
      tx_eop_i = eop && (i == pk.size() - 1);
      n = 0;
      hs = 1'b0;
      // Ready is read where it has settled, before the edge that takes
      while (!hs && n < 400)
      begin
        hs = (tx_ready_o === 1'b1);
        @(posedge clk_i);
        #1;
        n++;
      end
      if (!hs)
      begin
        error_cnt++;
        $display("ERROR tx_ready expected 1 seen %b", tx_ready_o);
        stop_test();
      end
    end
    tx_valid_i = 1'b0;
    // One edge with valid low keeps back-to-back packets apart
    @(posedge clk_i);
    #1;
  endtask

  task expect_rsp;
    int n;
    n = 0;
    while (rq.size() < ex.size() && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
    begin
      error_cnt++;
      $display("ERROR rsp_count expected %0d seen %0d", ex.size(), rq.size());
      stop_test();
    end
    // Extra cycles expose any surplus bytes
    repeat (4) @(posedge clk_i);
    #1;
    chk("rsp_len", ex.size(), rq.size());
    foreach (ex[i])
      chk("rsp_byte", {i == 0, i == ex.size() - 1, ex[i]}, rq[i]);
    rq.delete();
  endtask

  initial
  begin
    rst_i = 1'b1;
    tx_valid_i = 1'b0;
    tx_data_i = 8'h00;
    tx_sop_i = 1'b0;
    tx_eop_i = 1'b0;
    rx_ready_i = 1'b1;
    avm_waitrequest_i = 1'b0;
    error_cnt = 0;
    checked = 0;
    acc_cnt = 0;
    foreach (mem[i])
      mem[i] = 32'h0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    hdr(8'h04, 16'h0008, 32'h0000_0010);
    data(8, 8'h11);
    send(1'b1);
    rsp5(8'h04, 16'h0008);
    expect_rsp();
    chk("mem4", 32'h1413_1211, mem[4]);
    chk("mem5", 32'h1817_1615, mem[5]);
    hdr(8'h00, 16'h0008, 32'h0000_0020);
    data(8, 8'h21);
    send(1'b1);
    rsp5(8'h00, 16'h0008);
    expect_rsp();
    chk("mem8", 32'h2827_2625, mem[8]);
    chk("mem9", 32'h0, mem[9]);
    // Response side stalled while the read runs
    rx_ready_i = 1'b0;
    hdr(8'h14, 16'h0008, 32'h0000_0010);
    send(1'b1);
    repeat (20) @(posedge clk_i);
    #1;
    rx_ready_i = 1'b1;
    ex = {8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    expect_rsp();
    hdr(8'h10, 16'h0008, 32'h0000_0020);
    send(1'b1);
    ex = {8'h25, 8'h26, 8'h27, 8'h28, 8'h25, 8'h26, 8'h27, 8'h28};
    expect_rsp();
    acc0 = acc_cnt;
    foreach (odd[i])
    begin
      hdr(odd[i], 16'h0004, 32'h0000_0010);
      send(1'b1);
      rsp5(odd[i], 16'h0000);
      expect_rsp();
    end
    chk("bus_access", acc0, acc_cnt);
    hdr(8'h04, 16'h0008, 32'h0000_0030);
    data(3, 8'h31);
    send(1'b1);
    rsp5(8'h04, 16'h0003);
    expect_rsp();
    chk("mem12", 32'h0033_3231, mem[12]);
    hdr(8'h04, 16'h0008, 32'h0000_0038);
    data(2, 8'h41);
    send(1'b0);
    hdr(8'h7F, 16'h0000, 32'h0);
    send(1'b1);
    rsp5(8'h7F, 16'h0000);
    expect_rsp();
    chk("mem14", 32'h0, mem[14]);
    // Slave stalls until 10 cycles after the request buffer refuses
    avm_waitrequest_i = 1'b1;
    hdr(8'h04, 16'h0030, 32'h0000_0040);
    data(48, 8'h00);
    fork
      send(1'b1);
      begin
        wn = 0;
        while (tx_ready_o !== 1'b0 && wn < 300)
        begin
          @(posedge clk_i);
          wn++;
        end
        #1;
        chk("tx_ready", 32'h0, tx_ready_o);
        chk("write_held", 32'h1, avm_write_o);
        repeat (10) @(posedge clk_i);
        #1;
        avm_waitrequest_i = 1'b0;
      end
    join
    rsp5(8'h04, 16'h0030);
    expect_rsp();
    chk("mem27", 32'h2F2E_2D2C, mem[27]);
    stop_test();
  end
endmodule

`default_nettype wire
